// [pkg/pci_link_pkg.sv]
// constants and functions shared by both ends of the pci pin-level link
// assumes one 40 mhz core clock per end; the pci clock arrives as a sampled input at the target end and is made by the master end
// Contract
// - sample signals only on pci clock rise; the master end takes read data from ad on the fall
// - work at any clock up to 33.3 MHz (the master end makes a fixed 10 MHz pci clock from the 40 MHz core clock)
// - reset tri-states all outputs without clock
// - config cycles answered only with idsel asserted
// - one address phase, then data phases
// - ad[7:0] low byte, ad[31:24] high
// - read data valid while trdy asserted
// - cbe carries command in address phase
// - cbe are byte enables, bit 3 high
// - frame held during transfer, dropped on last
// - data phase completes when irdy and trdy
// - even parity over ad and cbe, one clock later
package pci_link_pkg;
  localparam int ad_w = 32;
  localparam int cbe_w = 4;
  localparam int core_mhz = 40;
  localparam int pci_max_khz = 33334;
  localparam logic [3:0] cmd_io_read = 4'h2;
  localparam logic [3:0] cmd_io_write = 4'h3;
  localparam logic [3:0] cmd_mem_read = 4'h6;
  localparam logic [3:0] cmd_mem_write = 4'h7;
  localparam logic [3:0] cmd_cfg_read = 4'ha;
  localparam logic [3:0] cmd_cfg_write = 4'hb;
  localparam logic [1:0] dword_low_bits = 2'h0;
  localparam logic [7:0] div_half = 8'h01;
  localparam logic [7:0] burst_max = 8'hff;

  function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
    even_par = ^{ad, cbe};
  endfunction : even_par

  function automatic logic is_write(input logic [3:0] cmd);
    is_write = cmd[0];
  endfunction : is_write
endpackage : pci_link_pkg

// [pkg/pci_link_if.sv]
// pin bundle joining the target end and the master end
// resolves each shared line here from its enables; only ad and par have two
`timescale 1ns/1ps
interface pci_link_if;
  logic pclk;
  logic [31:0] ad_m, ad_t;
  logic ad_m_oe, ad_t_oe;
  logic [3:0] cbe_m;
  logic cbe_m_oe;
  logic par_m, par_m_oe, par_t, par_t_oe;
  logic frame_n_m, frame_m_oe;
  logic irdy_n_m, irdy_m_oe;
  logic trdy_n_t, devsel_n_t, stop_n_t, tctl_t_oe;
  logic idsel;
  logic gnt_n;
  logic [31:0] ad;
  logic [3:0] cbe;
  logic par, frame_n, irdy_n, trdy_n, devsel_n, stop_n;
  assign ad = ad_m_oe ? ad_m : (ad_t_oe ? ad_t : 32'h0000_0000);
  assign cbe = cbe_m_oe ? cbe_m : 4'hf;
  assign par = par_m_oe ? par_m : (par_t_oe ? par_t : 1'b0);
  assign frame_n = frame_m_oe ? frame_n_m : 1'b1;
  assign irdy_n = irdy_m_oe ? irdy_n_m : 1'b1;
  assign trdy_n = tctl_t_oe ? trdy_n_t : 1'b1;
  assign devsel_n = tctl_t_oe ? devsel_n_t : 1'b1;
  assign stop_n = tctl_t_oe ? stop_n_t : 1'b1;
  modport target (input pclk, ad, cbe, frame_n, irdy_n, idsel,
    output ad_t, ad_t_oe, par_t, par_t_oe, trdy_n_t, devsel_n_t, stop_n_t, tctl_t_oe);
  modport master (input pclk, ad, trdy_n, devsel_n, stop_n, gnt_n,
    output ad_m, ad_m_oe, cbe_m, cbe_m_oe, par_m, par_m_oe,
    frame_n_m, frame_m_oe, irdy_n_m, irdy_m_oe);
endinterface : pci_link_if

// [logic/pci_target_end.sv]
// documented device end: pci target with a one-word register each for config and memory space
// assumes pclk, frame, irdy and idsel come from another domain and are synchronised here
`timescale 1ns/1ps
module pci_target_end
  import pci_link_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  pci_link_if.target bus,
  output logic [31:0] cfg_word,
  output logic [31:0] mem_word,
  output logic [3:0] last_cmd,
  output logic [31:0] last_addr,
  output logic access_pulse
);
  typedef enum logic [1:0] {t_idle, t_data, t_turn} tstate_t;
  typedef struct packed {
    logic [2:0] clk_s;
    logic [1:0] frame_s, irdy_s, idsel_s;
    logic [31:0] ad_s;
    logic [3:0] cbe_s;
    tstate_t st;
    logic is_cfg, wr;
    logic [3:0] cmd;
    logic [31:0] addr, cfg, mem, rdata;
    logic drive, rd_oe, par_oe, par, trdy, pulse, fr_was;
  } tgt_t;
  tgt_t s_q, s_d;
  logic rise;
  logic [31:0] lane_mask;

  // ************************************************************
  // ** pci clock edge detection on the core clock
  // ************************************************************
  assign rise = s_q.clk_s[1] & ~s_q.clk_s[2];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_mask[8*g +: 8] = {8{~s_q.cbe_s[g]}};
    end
  endgenerate

  // ************************************************************
  // ** target state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.clk_s = {s_q.clk_s[1:0], bus.pclk};
    s_d.frame_s = {s_q.frame_s[0], bus.frame_n};
    s_d.irdy_s = {s_q.irdy_s[0], bus.irdy_n};
    s_d.idsel_s = {s_q.idsel_s[0], bus.idsel};
    s_d.pulse = 1'b0;
    if (rise) begin
      // sample lines that settled over the previous pci cycle
      s_d.ad_s = bus.ad;
      s_d.cbe_s = bus.cbe;
      // frame level one pci cycle back, so only its falling cycle is an address phase
      s_d.fr_was = s_q.frame_s[1];
      // read parity covers the byte enables the master holds beside the data
      s_d.par = even_par(s_q.rdata, s_q.cbe_s);
      s_d.par_oe = s_q.rd_oe;
      unique case (s_q.st)
        t_idle: begin
          if (!s_q.frame_s[1] && s_q.fr_was) begin
            s_d.cmd = s_q.cbe_s;
            s_d.addr = s_q.ad_s;
            s_d.wr = is_write(s_q.cbe_s);
            s_d.is_cfg = (s_q.cbe_s == cmd_cfg_read) || (s_q.cbe_s == cmd_cfg_write);
            // config claimed only with idsel, memory always
            if ((s_d.is_cfg && s_q.idsel_s[1]) || s_q.cbe_s == cmd_mem_read
                || s_q.cbe_s == cmd_mem_write) begin
              s_d.st = t_data;
              s_d.drive = 1'b1;
              s_d.trdy = 1'b1;
              s_d.rdata = s_d.is_cfg ? s_q.cfg : s_q.mem;
              s_d.rd_oe = ~s_d.wr;
            end
          end
        end
        t_data: begin
          if (!s_q.irdy_s[1] && s_q.trdy) begin
            s_d.pulse = 1'b1;
            if (s_q.wr && s_q.is_cfg) begin
              s_d.cfg = (s_q.cfg & ~lane_mask) | (s_q.ad_s & lane_mask);
            end else if (s_q.wr) begin
              s_d.mem = (s_q.mem & ~lane_mask) | (s_q.ad_s & lane_mask);
            end
            if (s_q.frame_s[1]) begin
              s_d.st = t_turn;
              s_d.trdy = 1'b0;
              s_d.rd_oe = 1'b0;
            end
          end
        end
        t_turn: begin
          s_d.st = t_idle;
          s_d.drive = 1'b0;
        end
        default: s_d.st = t_idle;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= t_idle;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // ** pins and user side
  // ************************************************************
  assign bus.ad_t = s_q.rdata;
  assign bus.ad_t_oe = s_q.rd_oe & resetn;
  assign bus.par_t = s_q.par;
  assign bus.par_t_oe = s_q.par_oe & resetn;
  assign bus.trdy_n_t = ~s_q.trdy;
  assign bus.devsel_n_t = ~(s_q.st == t_data);
  assign bus.stop_n_t = 1'b1;
  assign bus.tctl_t_oe = s_q.drive & resetn;
  assign cfg_word = s_q.cfg;
  assign mem_word = s_q.mem;
  assign last_cmd = s_q.cmd;
  assign last_addr = s_q.addr;
  assign access_pulse = s_q.pulse;
endmodule : pci_target_end

// [logic/pci_master_end.sv]
// far end: pci master that runs one single-data-phase transaction per request
// assumes the target end answers with devsel and trdy; makes the pci clock by divider
`timescale 1ns/1ps
module pci_master_end
  import pci_link_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  pci_link_if.master bus,
  output logic pclk_out,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_be_n,
  output logic done_pulse,
  output logic [31:0] rd_data
);
  typedef enum logic [2:0] {m_idle, m_addr, m_data, m_turn} mstate_t;
  typedef struct packed {
    logic [7:0] div;
    logic pclk;
    logic [1:0] trdy_s, gnt_s;
    mstate_t st;
    logic wr;
    logic [31:0] ad, rdata;
    logic [3:0] cbe, be;
    logic [31:0] wdata;
    logic ad_oe, cbe_oe, frame, irdy, ctl_oe, par, par_oe, done;
  } mst_t;
  mst_t s_q, s_d;
  logic fall;

  // ************************************************************
  // ** pci clock divider: master changes outputs on the falling edge
  // ************************************************************
  assign fall = (s_q.div == div_half) && s_q.pclk;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.div = (s_q.div == div_half) ? 8'h00 : 8'(s_q.div + 8'h01);
    if (s_q.div == div_half) begin
      s_d.pclk = ~s_q.pclk;
    end
    if (s_q.div == div_half && !s_q.pclk) begin
      // rising edge of the pci clock about to occur: sample pins
      s_d.trdy_s = {s_q.trdy_s[0], bus.trdy_n};
      s_d.gnt_s = {s_q.gnt_s[0], bus.gnt_n};
    end
    if (fall) begin
      s_d.par = even_par(s_q.ad, s_q.cbe);
      s_d.par_oe = s_q.ad_oe && (s_q.st != m_data || s_q.wr);
      unique case (s_q.st)
        m_idle: begin
          if (req_valid && !s_q.gnt_s[1] && !s_q.frame) begin
            s_d.st = m_addr;
            s_d.wr = is_write(req_cmd);
            s_d.ad = (req_cmd == cmd_io_read || req_cmd == cmd_io_write) ? req_addr
              : {req_addr[31:2], dword_low_bits};
            s_d.cbe = req_cmd;
            s_d.be = req_be_n;
            s_d.wdata = req_wdata;
            s_d.ad_oe = 1'b1;
            s_d.cbe_oe = 1'b1;
            s_d.ctl_oe = 1'b1;
            s_d.frame = 1'b1;
          end
        end
        m_addr: begin
          s_d.st = m_data;
          s_d.frame = 1'b0;
          s_d.irdy = 1'b1;
          s_d.cbe = s_q.be;
          s_d.ad = s_q.wdata;
          s_d.ad_oe = s_q.wr;
        end
        m_data: begin
          if (!s_q.trdy_s[0]) begin
            s_d.rdata = bus.ad;
            s_d.irdy = 1'b0;
            s_d.st = m_turn;
            s_d.done = 1'b1;
          end
        end
        m_turn: begin
          s_d.st = m_idle;
          s_d.ad_oe = 1'b0;
          s_d.cbe_oe = 1'b0;
          s_d.ctl_oe = 1'b0;
        end
        default: s_d.st = m_idle;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.trdy_s <= 2'h3;
      s_q.gnt_s <= 2'h3;
      s_q.st <= m_idle;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // ** pins and user side
  // ************************************************************
  assign pclk_out = s_q.pclk;
  assign bus.ad_m = s_q.ad;
  assign bus.ad_m_oe = s_q.ad_oe & resetn;
  assign bus.cbe_m = s_q.cbe;
  assign bus.cbe_m_oe = s_q.cbe_oe & resetn;
  assign bus.par_m = s_q.par;
  assign bus.par_m_oe = s_q.par_oe & resetn;
  assign bus.frame_n_m = ~s_q.frame;
  assign bus.frame_m_oe = s_q.ctl_oe & resetn;
  assign bus.irdy_n_m = ~s_q.irdy;
  assign bus.irdy_m_oe = s_q.ctl_oe & resetn;
  assign req_ready = fall && s_q.st == m_idle && !s_q.gnt_s[1];
  assign done_pulse = s_q.done;
  assign rd_data = s_q.rdata;
endmodule : pci_master_end

// [bench/pci_link_properties.sv]
// concurrent checks on the shared pci lines between the two ends
// assumes the core clock samples pclk, which rises once every four core cycles
`timescale 1ns/1ps
module pci_link_properties (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pclk,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic idsel,
  input wire logic gnt_n,
  input wire logic ad_m_oe,
  input wire logic ad_t_oe,
  input wire logic cbe_m_oe,
  input wire logic par_m_oe,
  input wire logic par_t_oe,
  input wire logic frame_m_oe,
  input wire logic irdy_m_oe,
  input wire logic tctl_t_oe
);
  // ************************************************************
  // pclk rise tracking and assertions
  // ************************************************************
  logic pclk_q, fr_prev, par_exp, drv_prev;
  logic rise;
  assign rise = pclk & ~pclk_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pclk_q <= 1'b0;
      fr_prev <= 1'b1;
      par_exp <= 1'b0;
      drv_prev <= 1'b0;
    end else begin
      pclk_q <= pclk;
      if (rise) begin
        fr_prev <= frame_n;
        par_exp <= ^{ad, cbe};
        drv_prev <= ad_m_oe | ad_t_oe;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  reset_tristate_a: assert property (disable iff (1'b0) !resetn |-> !(ad_m_oe | ad_t_oe |
    cbe_m_oe | par_m_oe | par_t_oe | frame_m_oe | irdy_m_oe | tctl_t_oe))
    else $error("output driven during reset");
  even_parity_a: assert property (rise && (par_m_oe | par_t_oe) && drv_prev |-> par == par_exp)
    else $error("parity wrong");
  addr_phase_a: assert property (rise && !frame_n && fr_prev |-> irdy_n && ad_m_oe && cbe_m_oe)
    else $error("address phase malformed");
  cfg_unselected_a: assert property (rise && !frame_n && fr_prev && cbe[3:1] == 3'h5 && !idsel
    |=> devsel_n [*8]) else $error("config claimed without idsel");
  mem_claim_a: assert property (rise && !frame_n && fr_prev && cbe[3:1] == 3'h3
    |-> ##[1:16] !devsel_n) else $error("memory cycle not claimed");
  frame_last_a: assert property (rise && !irdy_n |-> frame_n)
    else $error("frame still low in final phase");
  irdy_hold_a: assert property (rise && !irdy_n && trdy_n |-> ##4 (!irdy_n && cbe == $past(cbe, 4)))
    else $error("data phase left before trdy");
  claimed_ready_a: assert property (!trdy_n |-> !devsel_n)
    else $error("trdy without devsel");
  grant_first_a: assert property ($rose(frame_m_oe) |-> !$past(gnt_n))
    else $error("frame driven without grant");
  cover property (rise && !frame_n && fr_prev && cbe == 4'h7);
  cover property (!devsel_n && idsel);
  cover property (rise && !irdy_n && trdy_n);
endmodule : pci_link_properties

// [bench/pci_pin_level_interface_bench.sv]
// self-checking bench: master end drives the target end over one link
// assumes the master makes pclk; bench drives idsel and gnt_n
`timescale 1ns/1ps
module pci_pin_level_interface_bench;
  import pci_link_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_cmd = 4'h0, req_be_n = 4'h0, last_cmd, seen_cmd;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, cfg_word, mem_word, last_addr, rd_data;
  logic [31:0] seen_addr;
  logic pclk_out, req_ready, done_pulse, access_pulse;
  logic fr_q = 1'b1;
  logic [31:0] n_access = 32'h0;
  logic [7:0] oes;
  int err_count = 0;
  int n_checks = 0;
  pci_link_if link();
  assign link.pclk = pclk_out;
  assign oes = {link.ad_m_oe, link.ad_t_oe, link.cbe_m_oe, link.par_m_oe, link.par_t_oe,
    link.frame_m_oe, link.irdy_m_oe, link.tctl_t_oe};
  always #12.5 clock = ~clock;
  pci_target_end i_pci_target_end (.clock(clock), .resetn(resetn), .bus(link),
    .cfg_word(cfg_word), .mem_word(mem_word), .last_cmd(last_cmd), .last_addr(last_addr),
    .access_pulse(access_pulse));
  pci_master_end i_pci_master_end (.clock(clock), .resetn(resetn), .bus(link),
    .pclk_out(pclk_out), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be_n(req_be_n),
    .done_pulse(done_pulse), .rd_data(rd_data));
  pci_link_properties i_pci_link_properties (.clock(clock), .resetn(resetn), .pclk(link.pclk),
    .ad(link.ad), .cbe(link.cbe), .par(link.par), .frame_n(link.frame_n), .irdy_n(link.irdy_n),
    .trdy_n(link.trdy_n), .devsel_n(link.devsel_n), .idsel(link.idsel), .gnt_n(link.gnt_n),
    .ad_m_oe(link.ad_m_oe), .ad_t_oe(link.ad_t_oe), .cbe_m_oe(link.cbe_m_oe),
    .par_m_oe(link.par_m_oe), .par_t_oe(link.par_t_oe), .frame_m_oe(link.frame_m_oe),
    .irdy_m_oe(link.irdy_m_oe), .tctl_t_oe(link.tctl_t_oe));
  // ************************************************************
  // wire monitor, checking and transfer tasks
  // ************************************************************
  // catches address and command on the first frame cycle
  always @(posedge link.pclk) begin
    if (!link.frame_n && fr_q) begin
      seen_addr <= link.ad;
      seen_cmd <= link.cbe;
    end
    fr_q <= link.frame_n;
  end
  // counts completed data phases seen by the target, sampled between edges
  always @(negedge clock) begin
    if (access_pulse === 1'b1) n_access = n_access + 32'h1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic do_req(input logic [3:0] c, input logic [31:0] a, input logic [31:0] w,
    input logic [3:0] b, input bit must);
    int n;
    n = 0;
    req_cmd = c;
    req_addr = a;
    req_wdata = w;
    req_be_n = b;
    req_valid = 1'b1;
    // ready is a one-cycle pulse: seen between edges, the request is taken at the next rise
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (done_pulse !== 1'b1 && n < 600) begin
      @(negedge clock);
      n++;
    end
    if (must) chk(32'(n < 600), 32'h1);
    // the target completes its data phase one sampled rise after the master
    repeat (8) @(negedge clock);
  endtask : do_req
  task automatic mid_reset;
    resetn = 1'b0;
    #1;
    chk({24'h0, oes}, 32'h0);
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    repeat (8) @(negedge clock);
    chk({24'h0, oes}, 32'h0);
  endtask : mid_reset
  task automatic t_reset;
    repeat (20) @(negedge clock);
    chk({24'h0, oes}, 32'h0);
    resetn = 1'b1;
    req_valid = 1'b1;
    req_cmd = cmd_mem_write;
    repeat (30) @(negedge clock);
    chk({24'h0, oes}, 32'h0);
    chk({31'h0, req_ready}, 32'h0);
    req_valid = 1'b0;
  endtask : t_reset
  task automatic t_mem;
    link.gnt_n = 1'b0;
    do_req(cmd_mem_write, 32'h0000_0013, 32'h1234_5678, 4'h0, 1'b1);
    chk(mem_word, 32'h1234_5678);
    chk({28'h0, seen_cmd}, {28'h0, cmd_mem_write});
    chk(seen_addr, 32'h0000_0010);
    chk(last_addr, 32'h0000_0010);
    do_req(cmd_mem_write, 32'h0000_0010, 32'haabb_ccdd, 4'h6, 1'b1);
    chk(mem_word, 32'haa34_56dd);
    do_req(cmd_mem_read, 32'h0000_0010, 32'h0, 4'h0, 1'b1);
    chk(rd_data, 32'haa34_56dd);
    chk({28'h0, last_cmd}, {28'h0, cmd_mem_read});
    chk(n_access, 32'h3);
  endtask : t_mem
  task automatic t_cfg;
    link.idsel = 1'b1;
    do_req(cmd_cfg_write, 32'h0000_0004, 32'hcafe_0001, 4'h0, 1'b1);
    chk(cfg_word, 32'hcafe_0001);
    do_req(cmd_cfg_read, 32'h0000_0004, 32'h0, 4'h0, 1'b1);
    chk(rd_data, 32'hcafe_0001);
    link.idsel = 1'b0;
    do_req(cmd_cfg_write, 32'h0000_0004, 32'h0, 4'h0, 1'b0);
    chk(cfg_word, 32'hcafe_0001);
    chk(n_access, 32'h5);
    // unclaimed cycle may leave the master waiting, so reset in mid-run
    mid_reset();
    // io cycles keep the low address bits, nobody claims them
    do_req(cmd_io_write, 32'h0000_0013, 32'h0, 4'h0, 1'b0);
    chk(seen_addr, 32'h0000_0013);
    chk({28'h0, seen_cmd}, {28'h0, cmd_io_write});
    mid_reset();
  endtask : t_cfg
  initial begin
    link.idsel = 1'b0;
    link.gnt_n = 1'b1;
    t_reset();
    t_mem();
    t_cfg();
    final_report();
  end
  initial begin
    #1000000;
    err_count++;
    final_report();
  end
endmodule : pci_pin_level_interface_bench
